// file: rtl/gpio_port_params.svh
// Purpose: Offsets, reset values and widths of the 16-pin port
// Assumes: Byte offsets on the peripheral bus, one word per register
// Notes: Definitions only
`ifndef GPIO_PORT_PARAMS_SVH
`define GPIO_PORT_PARAMS_SVH

`define GPIO_PINS 16
`define GPIO_ADDR_W 8
`define GPIO_OFS_CFG_A 8'h00
`define GPIO_OFS_CFG_B 8'h04
`define GPIO_OFS_CFG_C 8'h08
`define GPIO_OFS_DATA 8'h0c
`define GPIO_RST_CFG_A 16'hffff
`define GPIO_RST_CFG_B 16'h0000
`define GPIO_RST_CFG_C 16'h0000
`define GPIO_RST_DATA 16'h0000
`define GPIO_ALT_IN_IDLE 1'b0

`endif

// file: rtl/gpio_port_pkg.sv
// Purpose: Types shared by the port logic
// Assumes: Widths come from gpio_port_params.svh
// Notes: Pin modes are one-hot
`include "gpio_port_params.svh"

package gpio_port_pkg;

   typedef enum logic [7:0] {
      high_impedance_mode = 8'h01,
      input_mode = 8'h02,
      reserved_mode = 8'h04,
      weak_pull_input_mode = 8'h08,
      open_drain_output = 8'h10,
      push_pull_output = 8'h20,
      open_drain_alternate = 8'h40,
      push_pull_alternate = 8'h80
   } pin_mode_t;

   typedef struct packed {
      logic [`GPIO_PINS-1:0] cfg_a;
      logic [`GPIO_PINS-1:0] cfg_b;
      logic [`GPIO_PINS-1:0] cfg_c;
      logic [`GPIO_PINS-1:0] out_latch;
      logic [`GPIO_PINS-1:0] in_latch;
      logic [`GPIO_PINS-1:0] sync1;
      logic [`GPIO_PINS-1:0] sync2;
      logic [`GPIO_PINS-1:0] sync3;
      logic [`GPIO_PINS-1:0] rdata;
      logic slverr;
   } port_state_t;

endpackage

// file: rtl/gpio_port_16bit.sv
// Purpose: 16-pin general purpose port with per-pin mode selection
// Assumes: Peripheral bus access phase follows a setup phase
// Notes: Pads resolve pin_out/pin_oe and the weak pull outside
`timescale 1ns/1ns
`include "gpio_port_params.svh"

module gpio_port_16bit (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [`GPIO_ADDR_W-1:0] paddr_in,
   input wire logic [`GPIO_PINS-1:0] pwdata_in,
   output logic [`GPIO_PINS-1:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic [`GPIO_PINS-1:0] pin_in,
   output logic [`GPIO_PINS-1:0] pin_out,
   output logic [`GPIO_PINS-1:0] pin_oe_out,
   output logic [`GPIO_PINS-1:0] pin_pull_en_out,
   output logic [`GPIO_PINS-1:0] pin_pull_val_out,
   input wire logic [`GPIO_PINS-1:0] alt_out_in,
   output logic [`GPIO_PINS-1:0] alt_in_out
);

   gpio_port_pkg::port_state_t state_r;
   gpio_port_pkg::port_state_t state_nxt;
   gpio_port_pkg::pin_mode_t mode [`GPIO_PINS];
   logic [`GPIO_PINS-1:0] hiz_m;
   logic [`GPIO_PINS-1:0] in_m;
   logic [`GPIO_PINS-1:0] pull_m;
   logic [`GPIO_PINS-1:0] od_out_m;
   logic [`GPIO_PINS-1:0] pp_out_m;
   logic [`GPIO_PINS-1:0] od_alt_m;
   logic [`GPIO_PINS-1:0] pp_alt_m;
   logic [`GPIO_PINS-1:0] rsvd_m;
   logic [`GPIO_PINS-1:0] samp_m;
   logic [`GPIO_PINS-1:0] use_in_m;
   logic [`GPIO_PINS-1:0] read_mux;
   logic setup;
   logic access;
   logic word_ok;

   ////////////////////////////////////////////////////////////////////
   // Mode decode

   function automatic gpio_port_pkg::pin_mode_t mode_of(
      input logic a,
      input logic b,
      input logic c
   );
      logic [2:0] sel;
      sel = {c, b, a};
      unique case (sel)
         3'h0: mode_of = gpio_port_pkg::high_impedance_mode;
         3'h1: mode_of = gpio_port_pkg::input_mode;
         3'h2: mode_of = gpio_port_pkg::reserved_mode;
         3'h3: mode_of = gpio_port_pkg::weak_pull_input_mode;
         3'h4: mode_of = gpio_port_pkg::open_drain_output;
         3'h5: mode_of = gpio_port_pkg::push_pull_output;
         3'h6: mode_of = gpio_port_pkg::open_drain_alternate;
         3'h7: mode_of = gpio_port_pkg::push_pull_alternate;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Per-pin drive

   genvar i;
   generate
      for (i = 0; i < `GPIO_PINS; i++) begin : g_pin
         assign mode[i] = mode_of(state_r.cfg_a[i], state_r.cfg_b[i],
            state_r.cfg_c[i]);
         assign hiz_m[i] = mode[i] == gpio_port_pkg::high_impedance_mode;
         assign in_m[i] = mode[i] == gpio_port_pkg::input_mode;
         assign rsvd_m[i] = mode[i] == gpio_port_pkg::reserved_mode;
         assign pull_m[i] = mode[i] == gpio_port_pkg::weak_pull_input_mode;
         assign od_out_m[i] = mode[i] == gpio_port_pkg::open_drain_output;
         assign pp_out_m[i] = mode[i] == gpio_port_pkg::push_pull_output;
         assign od_alt_m[i] = mode[i] == gpio_port_pkg::open_drain_alternate;
         assign pp_alt_m[i] = mode[i] == gpio_port_pkg::push_pull_alternate;
         // Output, reserved and high impedance pins read back the driver-side level
         assign use_in_m[i] = in_m[i] | pull_m[i] | od_alt_m[i]
            | pp_alt_m[i];
         assign samp_m[i] = ~hiz_m[i] & ~rsvd_m[i];
         // Open-drain never drives high
         assign pin_out[i] = (pp_out_m[i] & state_r.out_latch[i])
            | (pp_alt_m[i] & alt_out_in[i]);
         assign pin_oe_out[i] = pp_out_m[i] | pp_alt_m[i]
            | (od_out_m[i] & ~state_r.out_latch[i])
            | (od_alt_m[i] & ~alt_out_in[i]);
         assign pin_pull_en_out[i] = pull_m[i];
         assign pin_pull_val_out[i] = pull_m[i]
            & state_r.out_latch[i];
         assign alt_in_out[i] = hiz_m[i] ? `GPIO_ALT_IN_IDLE
            : state_r.in_latch[i];
      end
   endgenerate

   assign read_mux = (use_in_m & state_r.in_latch)
      | (~use_in_m & state_r.out_latch);

   ////////////////////////////////////////////////////////////////////
   // Bus side

   assign setup = psel_in & ~penable_in;
   assign access = psel_in & penable_in;
   assign word_ok = paddr_in[1:0] == 2'h0 &&
      paddr_in <= `GPIO_OFS_DATA;
   assign pready_out = 1'b1;
   assign prdata_out = state_r.rdata;
   assign pslverr_out = access & state_r.slverr;

   ////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      state_nxt = state_r;
      state_nxt.sync1 = pin_in;
      state_nxt.sync2 = state_r.sync1;
      state_nxt.sync3 = state_r.sync2;
      // Take a pin level once the last two stages agree
      state_nxt.in_latch = (samp_m & ~(state_r.sync2 ^ state_r.sync3)
         & state_r.sync3) | (~(samp_m & ~(state_r.sync2 ^ state_r.sync3))
         & state_r.in_latch);
      if (setup) begin
         state_nxt.slverr = ~word_ok;
         state_nxt.rdata = '0;
         if (!pwrite_in) begin
            unique case (paddr_in)
               `GPIO_OFS_CFG_A: state_nxt.rdata = state_r.cfg_a;
               `GPIO_OFS_CFG_B: state_nxt.rdata = state_r.cfg_b;
               `GPIO_OFS_CFG_C: state_nxt.rdata = state_r.cfg_c;
               `GPIO_OFS_DATA: state_nxt.rdata = read_mux;
               default: state_nxt.rdata = '0;
            endcase
         end
      end
      if (access && pwrite_in && !state_r.slverr) begin
         unique case (paddr_in)
            `GPIO_OFS_CFG_A: state_nxt.cfg_a = pwdata_in;
            `GPIO_OFS_CFG_B: state_nxt.cfg_b = pwdata_in;
            `GPIO_OFS_CFG_C: state_nxt.cfg_c = pwdata_in;
            `GPIO_OFS_DATA: state_nxt.out_latch = pwdata_in;
            default: state_nxt.slverr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         state_r <= '0;
         state_r.cfg_a <= `GPIO_RST_CFG_A;
         state_r.cfg_b <= `GPIO_RST_CFG_B;
         state_r.cfg_c <= `GPIO_RST_CFG_C;
         state_r.out_latch <= `GPIO_RST_DATA;
      end else begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);

   // Reference decode taken from the raw configuration bits
   logic [`GPIO_PINS-1:0] ref_in_sel;
   assign ref_in_sel = (state_r.cfg_a & ~state_r.cfg_c)
      | (state_r.cfg_b & state_r.cfg_c);

   reset_config_a: assert property (disable iff (1'b0)
      $fell(rst_in) |-> state_r.cfg_a == `GPIO_RST_CFG_A
      && state_r.cfg_b == `GPIO_RST_CFG_B
      && state_r.cfg_c == `GPIO_RST_CFG_C)
      else $error("config not at reset value");

   data_write_a: assert property (access && pwrite_in
      && !state_r.slverr && paddr_in == `GPIO_OFS_DATA |=>
      state_r.out_latch == $past(pwdata_in))
      else $error("data write did not reach output latch");

   input_tristate_a: assert property (
      (~state_r.cfg_b & ~state_r.cfg_c & pin_oe_out) == 16'h0000)
      else $error("driver on in input or high impedance mode");

   data_read_a: assert property (setup && !pwrite_in
      && paddr_in == `GPIO_OFS_DATA |-> ##1
      prdata_out == $past((ref_in_sel & state_r.in_latch)
      | (~ref_in_sel & state_r.out_latch)) ##0 pslverr_out == 1'b0)
      else $error("data read mismatch");

   weak_pull_a: assert property (
      pin_pull_en_out == (state_r.cfg_a & state_r.cfg_b & ~state_r.cfg_c)
      && pin_pull_val_out == (pin_pull_en_out & state_r.out_latch)
      && (pin_pull_en_out & ~ref_in_sel) == 16'h0000)
      else $error("weak pull wrong");

   push_pull_a: assert property (
      ((pp_out_m & ~pin_oe_out) == 16'h0000)
      && ((pp_out_m & (pin_out ^ state_r.out_latch)) == 16'h0000))
      else $error("push-pull output wrong");

   alt_drive_a: assert property (
      ((pp_alt_m & (pin_out ^ alt_out_in)) == 16'h0000)
      && ((od_alt_m & (pin_oe_out ^ ~alt_out_in)) == 16'h0000))
      else $error("alternate drive wrong");

   open_drain_a: assert property (
      (((od_out_m | od_alt_m) & pin_out) == 16'h0000)
      && ((od_out_m & (pin_oe_out ^ ~state_r.out_latch))
      == 16'h0000))
      else $error("open-drain drive wrong");

   input_sample_a: assert property (1'b1 |=> ((state_r.in_latch
      ^ $past(state_r.sync3)) & $past(samp_m
      & ~(state_r.sync2 ^ state_r.sync3))) == 16'h0000)
      else $error("input latch missed a sample");

   alt_idle_a: assert property ((
      alt_in_out & ~(state_r.cfg_a | state_r.cfg_b | state_r.cfg_c))
      == 16'h0000)
      else $error("peripheral input not held in high impedance");

   bad_addr_a: assert property (setup && paddr_in[1:0] != 2'h0 |=>
      pslverr_out == penable_in)
      else $error("misaligned access not refused");

   cover_data_write_c: cover property (access && pwrite_in
      && paddr_in == `GPIO_OFS_DATA);
   cover_alt_pp_c: cover property (pp_alt_m[0] && alt_out_in[0]);
   cover_pull_read_c: cover property (pull_m[1] && setup && !pwrite_in
      && paddr_in == `GPIO_OFS_DATA);

endmodule

// file: test/gpio_pad_model.sv
// Purpose: Pads and outside drivers seen by the 16-pin port
// Assumes: One clock; the port samples the resolved levels
// Notes: A pin nobody drives or pulls toggles every cycle
`timescale 1ns/1ns
`include "gpio_port_params.svh"
module gpio_pad_model (
   input wire logic clk_sys_in,
   input wire logic [`GPIO_PINS-1:0] pin_out_in,
   input wire logic [`GPIO_PINS-1:0] pin_oe_in,
   input wire logic [`GPIO_PINS-1:0] pull_en_in,
   input wire logic [`GPIO_PINS-1:0] pull_val_in,
   input wire logic [`GPIO_PINS-1:0] ext_en_in,
   input wire logic [`GPIO_PINS-1:0] ext_val_in,
   output logic [`GPIO_PINS-1:0] level_out
);
   logic [`GPIO_PINS-1:0] float_r = 16'h0000;
   always @(posedge clk_sys_in) begin
      float_r <= ~float_r;
   end
   // Strong driver first, then the outside driver, then the weak pull
   always_comb begin
      for (int i = 0; i < `GPIO_PINS; i++) begin
         if (pin_oe_in[i]) begin
            level_out[i] = pin_out_in[i];
         end else if (ext_en_in[i]) begin
            level_out[i] = ext_val_in[i];
         end else if (pull_en_in[i]) begin
            level_out[i] = pull_val_in[i];
         end else begin
            level_out[i] = float_r[i];
         end
      end
   end
endmodule

// file: test/test_gpio_port_16bit.sv
// Purpose: Self-checking bench for the 16-pin port
// Assumes: No wait states; read data follows the setup edge
// Notes: Pins resolved by gpio_pad_model
`timescale 1ns/1ns
`include "gpio_port_params.svh"
module test_gpio_port_16bit;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [7:0] paddr_in = 8'h00;
   logic [15:0] pwdata_in = 16'h0000;
   logic [15:0] alt_out_in = 16'h0000;
   logic [15:0] ext_en = 16'hffff;
   logic [15:0] ext_val = 16'h0000;
   logic [15:0] prdata_out, pin_in, pin_out, pin_oe_out;
   logic [15:0] pull_en, pull_val, alt_in_out;
   logic pready_out, pslverr_out;
   int error_cnt = 0;
   int samples_checked = 0;
   always #5 clk_sys_in = ~clk_sys_in;
   gpio_port_16bit u_gpio_port_16bit (.clk_sys_in(clk_sys_in),
      .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
      .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_out(pin_oe_out), .pin_pull_en_out(pull_en),
      .pin_pull_val_out(pull_val), .alt_out_in(alt_out_in),
      .alt_in_out(alt_in_out));
   gpio_pad_model u_gpio_pad_model (.clk_sys_in(clk_sys_in),
      .pin_out_in(pin_out), .pin_oe_in(pin_oe_out), .pull_en_in(pull_en),
      .pull_val_in(pull_val), .ext_en_in(ext_en), .ext_val_in(ext_val),
      .level_out(pin_in));
   ////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("error_cnt=%0d samples_checked=%0d", error_cnt,
         samples_checked);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask
   // One setup and one access phase, then an idle cycle
   task automatic xfer(input int w, input logic [7:0] a,
         input int v, input int exp, input int err);
      int n;
      n = 0;
      psel_in = 1'b1;
      pwrite_in = w[0];
      paddr_in = a;
      pwdata_in = v[15:0];
      @(posedge clk_sys_in);
      #1 penable_in = 1'b1;
      // Answer is taken at the edge that samples ready high
      @(posedge clk_sys_in);
      while (pready_out !== 1'b1) begin
         n++;
         if (n > 8) begin
            error_cnt++;
            complete_run();
         end
         @(posedge clk_sys_in);
      end
      if (!w) begin
         chk(prdata_out, exp[15:0]);
      end
      chk({15'h0000, pslverr_out}, {15'h0000, err[0]});
      #1 psel_in = 1'b0;
      penable_in = 1'b0;
      idle(1);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      idle(6);
      rst_in = 1'b0;
      chk(pin_oe_out, 16'h0000);
      xfer(0, `GPIO_OFS_CFG_A, 0, `GPIO_RST_CFG_A, 0);
      xfer(0, `GPIO_OFS_CFG_B, 0, `GPIO_RST_CFG_B, 0);
      xfer(0, `GPIO_OFS_CFG_C, 0, `GPIO_RST_CFG_C, 0);
      xfer(0, `GPIO_OFS_DATA, 0, `GPIO_RST_DATA, 0);
      xfer(0, 8'h10, 0, 16'h0000, 1);
      xfer(1, 8'h02, 16'h5555, 0, 1);
      ext_val = 16'h3c3c;
      xfer(1, `GPIO_OFS_DATA, 16'ha5a5, 0, 0);
      idle(6);
      xfer(0, `GPIO_OFS_DATA, 0, 16'h3c3c, 0);
      chk(alt_in_out, 16'h3c3c);
      ext_en = 16'h0000;
      xfer(1, `GPIO_OFS_CFG_C, 16'hffff, 0, 0);
      chk(pin_oe_out, 16'hffff);
      chk(pin_out, 16'ha5a5);
      xfer(0, `GPIO_OFS_DATA, 0, 16'ha5a5, 0);
      xfer(1, `GPIO_OFS_CFG_A, 16'h0000, 0, 0);
      chk(pin_oe_out, 16'h5a5a);
      chk(pin_out, 16'h0000);
      alt_out_in = 16'h1234;
      xfer(1, `GPIO_OFS_CFG_B, 16'hffff, 0, 0);
      chk(pin_oe_out, 16'hedcb);
      xfer(1, `GPIO_OFS_CFG_A, 16'hffff, 0, 0);
      chk(pin_out, 16'h1234);
      chk(pin_oe_out, 16'hffff);
      idle(6);
      xfer(0, `GPIO_OFS_DATA, 0, 16'h1234, 0);
      chk(alt_in_out, 16'h1234);
      xfer(1, `GPIO_OFS_CFG_C, 16'h0000, 0, 0);
      xfer(1, `GPIO_OFS_DATA, 16'h00ff, 0, 0);
      chk(pull_en, 16'hffff);
      chk(pull_val, 16'h00ff);
      chk(pin_oe_out, 16'h0000);
      idle(6);
      xfer(0, `GPIO_OFS_DATA, 0, 16'h00ff, 0);
      xfer(1, `GPIO_OFS_CFG_A, 16'h0000, 0, 0);
      chk(pin_oe_out, 16'h0000);
      xfer(0, `GPIO_OFS_CFG_B, 0, 16'hffff, 0);
      xfer(1, `GPIO_OFS_CFG_B, 16'h0000, 0, 0);
      ext_en = 16'hffff;
      ext_val = 16'hffff;
      xfer(1, `GPIO_OFS_DATA, 16'h0f0f, 0, 0);
      idle(6);
      chk(pin_oe_out, 16'h0000);
      chk(alt_in_out, {16{`GPIO_ALT_IN_IDLE}});
      xfer(0, `GPIO_OFS_DATA, 0, 16'h0f0f, 0);
      // Second reset in mid-run must restore the configuration
      rst_in = 1'b1;
      idle(2);
      chk(pin_oe_out, 16'h0000);
      rst_in = 1'b0;
      xfer(0, `GPIO_OFS_CFG_A, 0, `GPIO_RST_CFG_A, 0);
      xfer(0, `GPIO_OFS_CFG_C, 0, `GPIO_RST_CFG_C, 0);
      complete_run();
   end
endmodule
